/* File: line_path_error_counters_regs.svh */
// Register offsets, field positions, reset values and timing figures of the error counters.
`ifndef LINE_PATH_ERROR_COUNTERS_REGS_SVH
`define LINE_PATH_ERROR_COUNTERS_REGS_SVH

`define ADDR_W 8
`define OFS_COUNTER_CONFIG 8'h00
`define OFS_STATUS 8'h04
`define OFS_LCV_HIGH 8'h08
`define OFS_LCV_LOW 8'h0c
`define OFS_PATH_HIGH 8'h10
`define OFS_PATH_LOW 8'h14
`define OFS_FSE_HIGH 8'h18
`define OFS_FSE_LOW 8'h1c
`define OFS_FEBE_HIGH 8'h20
`define OFS_FEBE_LOW 8'h24

`define CFG_LC_SELECT 0
`define CFG_FS_FBIT_MODE 1
`define CFG_COUNT_FS 2
`define CFG_UPD_LSB 3
`define CFG_UPD_MSB 5
`define CFG_E1_MODE 6
`define CFG_ESF 7
`define CFG_ZERO_SUB 8
`define CFG_CRC4_MF 9
`define CFG_MANUAL_UPDATE 10
`define CFG_WIDTH 11
`define CFG_RESET 11'h000

`define CNT_MAX 16'hffff
`define T1_ZERO_RUN 5'h10
`define B8ZS_ZERO_RUN 5'h08
`define SUB_ZEROS 5'h03
`define HDB3_SHORT_ZEROS 5'h02
`define B8ZS_SECOND_V_ZEROS 5'h01

`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`define CLK_MHZ 20
`define ONE_SECOND_US 1000000
`define T1_INTERVAL_US 42000
`define E1_INTERVAL_US 62500

`endif

/* File: line_path_error_counters_pkg.sv */
// Types shared by the error counter block.
package line_path_error_counters_pkg;

   typedef enum logic [2:0] {
      upd_own_second = 3'h0,
      upd_own_short = 3'h1,
      upd_software = 3'h2,
      upd_shared_second = 3'h3,
      upd_shared_manual = 3'h4
   } update_source_t;

   typedef enum logic [1:0] {
      bus_idle = 2'b01,
      bus_resp = 2'b10
   } bus_state_t;

endpackage

/* File: line_path_error_counters.sv */
// Line, path, frame-sync and far-end block error counters with an AXI4-Lite register port.
//
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "line_path_error_counters_regs.svh"

module line_path_error_counters #(
   parameter int unsigned SECOND_CYCLES = `ONE_SECOND_US * `CLK_MHZ,
   parameter int unsigned T1_CYCLES = `T1_INTERVAL_US * `CLK_MHZ,
   parameter int unsigned E1_CYCLES = `E1_INTERVAL_US * `CLK_MHZ
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic ce,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [`ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [`ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic rx_bit_strobe,
   input wire logic rx_pos,
   input wire logic rx_neg,
   input wire logic receive_out_of_frame,
   input wire logic crc4_sync_lost,
   input wire logic align_search,
   input wire logic crc6_error,
   input wire logic ft_error,
   input wire logic fs_error,
   input wire logic fps_error,
   input wire logic crc4_error,
   input wire logic fas_word_error,
   input wire logic multiframe_tick,
   input wire logic ebit_strobe,
   input wire logic ebit_value,
   input wire logic shared_second_in,
   input wire logic shared_manual_in,
   output logic second_tick_out,
   output logic update_out
);

   logic [`CFG_WIDTH-1:0] cfg_reg;
   logic [31:0] sec_cnt_reg;
   logic [31:0] short_cnt_reg;
   logic sw_update_reg;
   logic [15:0] run_reg [4];
   logic [15:0] held_reg [4];
   logic last_pol_reg;
   logic have_mark_reg;
   logic last_bpv_pol_reg;
   logic have_bpv_reg;
   logic cw_pending_reg;
   logic [4:0] zeros_reg;
   line_path_error_counters_pkg::bus_state_t wr_state_reg;
   line_path_error_counters_pkg::bus_state_t rd_state_reg;

   // Configuration fields.
   wire lc_select = cfg_reg[`CFG_LC_SELECT];
   wire fs_fbit_mode = cfg_reg[`CFG_FS_FBIT_MODE];
   wire count_fs = cfg_reg[`CFG_COUNT_FS];
   wire e1_mode = cfg_reg[`CFG_E1_MODE];
   wire esf = cfg_reg[`CFG_ESF];
   wire zero_sub = cfg_reg[`CFG_ZERO_SUB];
   wire crc4_mf = cfg_reg[`CFG_CRC4_MF];
   wire [2:0] upd_field = cfg_reg[`CFG_UPD_MSB:`CFG_UPD_LSB];

   // Interval timers; the own second always runs so other ports may share it.
   wire sec_end = sec_cnt_reg == SECOND_CYCLES - 1;
   wire [31:0] short_len = e1_mode ? E1_CYCLES : T1_CYCLES;
   wire short_end = short_cnt_reg >= short_len - 1;

   logic update_evt;
   always_comb begin
      case (upd_field)
         line_path_error_counters_pkg::upd_own_second: update_evt = sec_end;
         line_path_error_counters_pkg::upd_own_short: update_evt = short_end;
         line_path_error_counters_pkg::upd_software: update_evt = sw_update_reg;
         line_path_error_counters_pkg::upd_shared_second: update_evt = shared_second_in;
         line_path_error_counters_pkg::upd_shared_manual: update_evt = shared_manual_in;
         default: update_evt = 1'b0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sec_cnt_reg <= 32'h0;
         short_cnt_reg <= 32'h0;
         second_tick_out <= 1'b0;
         update_out <= 1'b0;
      end else if (ce) begin
         sec_cnt_reg <= sec_end ? 32'h0 : sec_cnt_reg + 32'h1;
         short_cnt_reg <= short_end ? 32'h0 : short_cnt_reg + 32'h1;
         second_tick_out <= sec_end;
         update_out <= update_evt;
      end
   end

   // Line decoder: a mark equal in polarity to the previous mark is a violation.
   wire mark = rx_bit_strobe && (rx_pos ^ rx_neg);
   // No violation is judged until a first mark has set the reference polarity.
   wire bpv_raw = mark && have_mark_reg && (rx_pos == last_pol_reg);
   wire b8zs_v = zeros_reg == `SUB_ZEROS || (cw_pending_reg && zeros_reg == `B8ZS_SECOND_V_ZEROS);
   wire hdb3_v = zeros_reg == `SUB_ZEROS || zeros_reg == `HDB3_SHORT_ZEROS;
   wire excused = zero_sub && (e1_mode ? hdb3_v : b8zs_v);
   wire bpv = bpv_raw && !excused;
   wire cv = bpv && have_bpv_reg && (rx_pos == last_bpv_pol_reg);
   wire [4:0] zero_limit = zero_sub ? `B8ZS_ZERO_RUN : `T1_ZERO_RUN;
   wire zero_run = rx_bit_strobe && !mark && zeros_reg == zero_limit - 5'h1;
   wire lcv_evt = (e1_mode && lc_select) ? cv
      : (bpv || (!e1_mode && lc_select && zero_run));

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         last_pol_reg <= 1'b0;
         have_mark_reg <= 1'b0;
         last_bpv_pol_reg <= 1'b0;
         have_bpv_reg <= 1'b0;
         cw_pending_reg <= 1'b0;
         zeros_reg <= 5'h0;
      end else if (ce && rx_bit_strobe) begin
         if (mark) begin
            last_pol_reg <= rx_pos;
            have_mark_reg <= 1'b1;
            zeros_reg <= 5'h0;
            // A codeword runs V, B, zero, V; the pending mark must survive the B.
            cw_pending_reg <= (bpv_raw && excused && zeros_reg == `SUB_ZEROS)
               || (cw_pending_reg && !bpv_raw && zeros_reg == 5'h0);
            if (bpv) begin
               last_bpv_pol_reg <= rx_pos;
               have_bpv_reg <= 1'b1;
            end
         end else if (zeros_reg != `T1_ZERO_RUN) begin
            zeros_reg <= zeros_reg + 5'h1;
         end
      end
   end

   // Path, frame-sync and far-end block error events with their gating.
   wire t1_path = !receive_out_of_frame
      && (esf ? crc6_error : (ft_error || (count_fs && fs_error)));
   wire e1_path = crc4_error && !receive_out_of_frame && !crc4_sync_lost;
   wire path_evt = e1_mode ? e1_path : t1_path;
   wire t1_fse = fs_fbit_mode ? (!receive_out_of_frame && (esf ? fps_error : ft_error))
      : (multiframe_tick && receive_out_of_frame);
   wire e1_fse = fas_word_error && !receive_out_of_frame && !align_search;
   wire fse_evt = e1_mode ? e1_fse : t1_fse;
   wire febe_evt = e1_mode && crc4_mf && ebit_strobe && !ebit_value
      && !receive_out_of_frame && !crc4_sync_lost;

   wire [3:0] evt = {febe_evt, fse_evt, path_evt, lcv_evt};

   // One saturating counter per error class; an event in the update cycle opens the new interval.
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_cnt
         wire [15:0] run_next = update_evt ? {15'h0, evt[gi]}
            : ((evt[gi] && run_reg[gi] != `CNT_MAX) ? run_reg[gi] + 16'h1 : run_reg[gi]);
         always_ff @(posedge clk) begin
            if (sys_rst) begin
               run_reg[gi] <= 16'h0;
               held_reg[gi] <= 16'h0;
            end else if (ce) begin
               run_reg[gi] <= run_next;
               if (update_evt) begin
                  held_reg[gi] <= run_reg[gi];
               end
            end
         end
      end
   endgenerate

   // AXI4-Lite slave: ready pulses the cycle after a take, the response follows that handshake.
   wire wr_take = wr_state_reg == line_path_error_counters_pkg::bus_idle
      && s_axi_awvalid && s_axi_wvalid;
   wire rd_take = rd_state_reg == line_path_error_counters_pkg::bus_idle && s_axi_arvalid;
   wire wr_cfg = wr_take && s_axi_awaddr == `OFS_COUNTER_CONFIG;
   wire wr_known = s_axi_awaddr == `OFS_COUNTER_CONFIG || s_axi_awaddr == `OFS_STATUS;
   wire [`CFG_WIDTH-2:0] cfg_next = {
      s_axi_wstrb[1] ? s_axi_wdata[`CFG_WIDTH-2:8] : cfg_reg[`CFG_WIDTH-2:8],
      s_axi_wstrb[0] ? s_axi_wdata[7:0] : cfg_reg[7:0]};
   wire sw_pulse = wr_cfg && s_axi_wstrb[1] && s_axi_wdata[`CFG_MANUAL_UPDATE];

   logic [31:0] rd_data;
   logic rd_known;
   always_comb begin
      rd_known = 1'b1;
      case (s_axi_araddr)
         `OFS_COUNTER_CONFIG: rd_data = {21'h0, 1'b0, cfg_reg[`CFG_WIDTH-2:0]};
         `OFS_STATUS: rd_data = {31'h0, receive_out_of_frame};
         `OFS_LCV_HIGH: rd_data = {24'h0, held_reg[0][15:8]};
         `OFS_LCV_LOW: rd_data = {24'h0, held_reg[0][7:0]};
         `OFS_PATH_HIGH: rd_data = {24'h0, held_reg[1][15:8]};
         `OFS_PATH_LOW: rd_data = {24'h0, held_reg[1][7:0]};
         `OFS_FSE_HIGH: rd_data = {24'h0, held_reg[2][15:8]};
         `OFS_FSE_LOW: rd_data = {24'h0, held_reg[2][7:0]};
         `OFS_FEBE_HIGH: rd_data = {24'h0, held_reg[3][15:8]};
         `OFS_FEBE_LOW: rd_data = {24'h0, held_reg[3][7:0]};
         default: begin
            rd_data = 32'h0;
            rd_known = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cfg_reg <= `CFG_RESET;
         sw_update_reg <= 1'b0;
         wr_state_reg <= line_path_error_counters_pkg::bus_idle;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end else if (ce) begin
         s_axi_awready <= wr_take;
         s_axi_wready <= wr_take;
         sw_update_reg <= sw_pulse;
         if (wr_cfg) begin
            cfg_reg <= {1'b0, cfg_next[`CFG_WIDTH-2:0]};
         end
         case (wr_state_reg)
            line_path_error_counters_pkg::bus_idle: begin
               if (wr_take) begin
                  wr_state_reg <= line_path_error_counters_pkg::bus_resp;
                  s_axi_bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
               end
            end
            line_path_error_counters_pkg::bus_resp: begin
               // The response may only follow the address and data handshakes.
               if (s_axi_awready) begin
                  s_axi_bvalid <= 1'b1;
               end else if (s_axi_bvalid && s_axi_bready) begin
                  wr_state_reg <= line_path_error_counters_pkg::bus_idle;
                  s_axi_bvalid <= 1'b0;
               end
            end
            default: wr_state_reg <= line_path_error_counters_pkg::bus_idle;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rd_state_reg <= line_path_error_counters_pkg::bus_idle;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `RESP_OKAY;
      end else if (ce) begin
         s_axi_arready <= rd_take;
         case (rd_state_reg)
            line_path_error_counters_pkg::bus_idle: begin
               if (rd_take) begin
                  rd_state_reg <= line_path_error_counters_pkg::bus_resp;
                  s_axi_rdata <= rd_data;
                  s_axi_rresp <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
               end
            end
            line_path_error_counters_pkg::bus_resp: begin
               // Read data are offered only after the address handshake.
               if (s_axi_arready) begin
                  s_axi_rvalid <= 1'b1;
               end else if (s_axi_rvalid && s_axi_rready) begin
                  rd_state_reg <= line_path_error_counters_pkg::bus_idle;
                  s_axi_rvalid <= 1'b0;
               end
            end
            default: rd_state_reg <= line_path_error_counters_pkg::bus_idle;
         endcase
      end
   end

   // Checks on the counting behaviour.
   property p_latch_copies;
      @(posedge clk) disable iff (sys_rst)
      (ce && update_evt) |=> held_reg[1] == $past(run_reg[1]);
   endproperty
   a_latch_copies: assert property (p_latch_copies) else $error("held not copied");

   property p_restart;
      @(posedge clk) disable iff (sys_rst)
      (ce && update_evt && !evt[0]) |=> run_reg[0] == 16'h0;
   endproperty
   a_restart: assert property (p_restart) else $error("running count not restarted");

   property p_saturate;
      @(posedge clk) disable iff (sys_rst)
      (ce && !update_evt && run_reg[0] == `CNT_MAX) |=> run_reg[0] == `CNT_MAX;
   endproperty
   a_saturate: assert property (p_saturate) else $error("counter wrapped");

   property p_count_step;
      @(posedge clk) disable iff (sys_rst)
      (ce && !update_evt && evt[3] && run_reg[3] != `CNT_MAX)
         |=> run_reg[3] == $past(run_reg[3]) + 16'h1;
   endproperty
   a_count_step: assert property (p_count_step) else $error("far-end count missed");

   property p_t1_path_gate;
      @(posedge clk) disable iff (sys_rst)
      (!e1_mode && receive_out_of_frame) |-> !path_evt;
   endproperty
   a_t1_path_gate: assert property (p_t1_path_gate) else $error("t1 path gate");

   property p_e1_path_gate;
      @(posedge clk) disable iff (sys_rst)
      (e1_mode && crc4_sync_lost) |-> !path_evt && !febe_evt;
   endproperty
   a_e1_path_gate: assert property (p_e1_path_gate) else $error("crc4 gate");

   property p_mos_count;
      @(posedge clk) disable iff (sys_rst)
      (!e1_mode && !fs_fbit_mode && multiframe_tick && receive_out_of_frame) |-> fse_evt;
   endproperty
   a_mos_count: assert property (p_mos_count) else $error("multiframe missed");

   property p_fbit_gate;
      @(posedge clk) disable iff (sys_rst)
      ((e1_mode || fs_fbit_mode) && receive_out_of_frame) |-> !fse_evt;
   endproperty
   a_fbit_gate: assert property (p_fbit_gate) else $error("fse gate");

   property p_bpv;
      @(posedge clk) disable iff (sys_rst)
      (mark && have_mark_reg && !zero_sub && !lc_select && rx_pos == last_pol_reg) |-> lcv_evt;
   endproperty
   a_bpv: assert property (p_bpv) else $error("bipolar violation missed");

   property p_second;
      @(posedge clk) disable iff (sys_rst)
      (ce && sec_end) |=> second_tick_out;
   endproperty
   a_second: assert property (p_second) else $error("second tick missing");

   c_update: cover property (@(posedge clk) disable iff (sys_rst)
      ce && update_evt && run_reg[0] != 16'h0);
   c_saturate: cover property (@(posedge clk) disable iff (sys_rst)
      ce && evt[1] && run_reg[1] == `CNT_MAX);
   c_excused: cover property (@(posedge clk) disable iff (sys_rst) bpv_raw && excused);
   c_zero_run: cover property (@(posedge clk) disable iff (sys_rst) zero_run && lcv_evt);

endmodule // line_path_error_counters

/* File: line_symbol_source.sv */
// Receive line model that turns bench symbols into strobed polarity bits.
`timescale 1ns/1ps

module line_symbol_source (
   input wire logic clk,
   input wire logic sym_valid,
   input wire logic [1:0] sym_code,
   output logic rx_bit_strobe,
   output logic rx_pos,
   output logic rx_neg
);
   initial begin
      rx_bit_strobe = 1'b0;
      rx_pos = 1'b0;
      rx_neg = 1'b1;
   end
   // Between bits the polarity lines churn, so a decoder that ignores the strobe is caught.
   always @(posedge clk) begin
      rx_bit_strobe <= sym_valid;
      if (sym_valid) begin
         rx_pos <= (sym_code == 2'h1);
         rx_neg <= (sym_code == 2'h2);
      end else begin
         rx_pos <= ~rx_pos;
         rx_neg <= rx_pos;
      end
   end
endmodule // line_symbol_source

/* File: tb_line_path_error_counters.sv */
// Self-checking bench for the line, path, frame-sync and far-end block error counters.
`timescale 1ns/1ps
`include "line_path_error_counters_regs.svh"

module tb_line_path_error_counters;
   typedef struct {
      logic [10:0] cfg;
      logic [8:0] ev;
      logic [2:0] lvl;
      logic [7:0] ofs;
      logic [15:0] want;
   } row_t;
   logic clk, sys_rst, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0] s_axi_awprot, s_axi_arprot, lvl;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, sym_code;
   logic rx_bit_strobe, rx_pos, rx_neg, receive_out_of_frame, crc4_sync_lost, align_search;
   logic crc6_error, ft_error, fs_error, fps_error, crc4_error, fas_word_error;
   logic multiframe_tick, ebit_strobe, ebit_value, shared_second_in, shared_manual_in;
   logic second_tick_out, update_out, sym_valid;
   logic [8:0] ev;
   int n_mismatch = 0;
   int n_compared = 0;
   // Event rows: config, event pulse, levels {search, sync lost, out of frame}, register, count.
   row_t rows[22] = '{
      '{11'h010, 9'h002, 3'h0, `OFS_PATH_LOW, 16'h3},
      '{11'h010, 9'h004, 3'h0, `OFS_PATH_LOW, 16'h0},
      '{11'h014, 9'h004, 3'h0, `OFS_PATH_LOW, 16'h3},
      '{11'h094, 9'h004, 3'h0, `OFS_PATH_LOW, 16'h0},
      '{11'h090, 9'h001, 3'h0, `OFS_PATH_LOW, 16'h3},
      '{11'h010, 9'h002, 3'h1, `OFS_PATH_LOW, 16'h0},
      '{11'h012, 9'h002, 3'h0, `OFS_FSE_LOW, 16'h3},
      '{11'h092, 9'h008, 3'h0, `OFS_FSE_LOW, 16'h3},
      '{11'h092, 9'h008, 3'h1, `OFS_FSE_LOW, 16'h0},
      '{11'h010, 9'h040, 3'h1, `OFS_FSE_LOW, 16'h3},
      '{11'h010, 9'h040, 3'h0, `OFS_FSE_LOW, 16'h0},
      '{11'h050, 9'h010, 3'h0, `OFS_PATH_LOW, 16'h3},
      '{11'h050, 9'h010, 3'h2, `OFS_PATH_LOW, 16'h0},
      '{11'h050, 9'h010, 3'h4, `OFS_PATH_LOW, 16'h3},
      '{11'h050, 9'h020, 3'h0, `OFS_FSE_LOW, 16'h3},
      '{11'h050, 9'h020, 3'h4, `OFS_FSE_LOW, 16'h0},
      '{11'h050, 9'h020, 3'h1, `OFS_FSE_LOW, 16'h0},
      '{11'h250, 9'h080, 3'h0, `OFS_FEBE_LOW, 16'h3},
      '{11'h250, 9'h100, 3'h0, `OFS_FEBE_LOW, 16'h0},
      '{11'h050, 9'h080, 3'h0, `OFS_FEBE_LOW, 16'h0},
      '{11'h210, 9'h080, 3'h0, `OFS_FEBE_LOW, 16'h0},
      '{11'h250, 9'h080, 3'h2, `OFS_FEBE_LOW, 16'h0}
   };

   assign {fs_error, ft_error, crc6_error} = ev[2:0];
   assign {multiframe_tick, fas_word_error, crc4_error, fps_error} = ev[6:3];
   assign ebit_strobe = ev[7] | ev[8];
   assign ebit_value = ev[8];
   assign {align_search, crc4_sync_lost, receive_out_of_frame} = lvl;

   line_path_error_counters #(
      .SECOND_CYCLES(100),
      .T1_CYCLES(20),
      .E1_CYCLES(30)
   ) i_line_path_error_counters (.*);

   line_symbol_source i_line_symbol_source (.*);

   task automatic summarize();
      $display("Counts: %0d mismatches, %0d comparisons", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic fail(input string m);
      n_mismatch++;
      $display("MISMATCH t=%0t %s", $time, m);
   endtask

   task automatic check32(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) fail($sformatf("data %h expected %h", g, e));
   endtask

   task automatic check_resp(input logic [1:0] g, input logic [1:0] e);
      n_compared++;
      if (g !== e) fail($sformatf("response %h expected %h", g, e));
   endtask

   task automatic check_num(input int g, input int e);
      n_compared++;
      if (g != e) fail($sformatf("count %0d expected %0d", g, e));
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int n = 0;
      bit a_ok = 0, w_ok = 0, b_ok = 0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(a_ok && w_ok && b_ok) && n < 40) begin
         @(posedge clk);
         n++;
         if (s_axi_awready === 1'b1) begin
            a_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready === 1'b1) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
         if (s_axi_bvalid === 1'b1) begin
            b_ok = 1'b1;
            r = s_axi_bresp;
         end
      end
      if (!(a_ok && w_ok && b_ok)) begin
         fail("write timeout");
         summarize();
      end
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n = 0;
      bit a_ok = 0, r_ok = 0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      while (!(a_ok && r_ok) && n < 40) begin
         @(posedge clk);
         n++;
         if (s_axi_arready === 1'b1) begin
            a_ok = 1'b1;
            s_axi_arvalid <= 1'b0;
         end
         if (s_axi_rvalid === 1'b1) begin
            r_ok = 1'b1;
            d = s_axi_rdata;
            r = s_axi_rresp;
         end
      end
      if (!(a_ok && r_ok)) begin
         fail("read timeout");
         summarize();
      end
   endtask

   task automatic rd_count(input logic [7:0] a, input logic [15:0] e);
      logic [31:0] d;
      logic [1:0] r;
      rd(a - 8'h4, d, r);
      check32(d, {24'h0, e[15:8]});
      rd(a, d, r);
      check32(d, {24'h0, e[7:0]});
   endtask

   task automatic set_cfg(input logic [10:0] c);
      logic [1:0] r;
      wr(`OFS_COUNTER_CONFIG, {21'h0, c}, r);
   endtask

   task automatic run_row(input row_t w);
      lvl <= w.lvl;
      set_cfg(w.cfg | 11'h400);
      // The fourth pulse arrives with the clock enable low and must be lost.
      for (int i = 0; i < 4; i++) begin
         ce <= (i < 3);
         ev <= w.ev;
         @(posedge clk);
         ev <= 9'h0;
         ce <= 1'b1;
         @(posedge clk);
      end
      set_cfg(w.cfg | 11'h400);
      rd_count(w.ofs, w.want);
   endtask

   task automatic send(input string s);
      for (int i = 0; i < s.len(); i++) begin
         sym_valid <= 1'b1;
         sym_code <= (s[i] == "+") ? 2'h1 : (s[i] == "-") ? 2'h2 : 2'h0;
         @(posedge clk);
         if (i % 3 == 2) begin
            sym_valid <= 1'b0;
            repeat (2) @(posedge clk);
         end
      end
      sym_valid <= 1'b0;
      repeat (3) @(posedge clk);
   endtask

   task automatic line_case(input logic [10:0] c, input string p, input string s,
                            input logic [15:0] e);
      set_cfg(c);
      send(p);
      set_cfg(c | 11'h400);
      send(s);
      set_cfg(c | 11'h400);
      rd_count(`OFS_LCV_LOW, e);
   endtask

   task automatic wait_pulse(input bit s, input int lim, input bit must, output int n);
      n = 0;
      while ((s ? second_tick_out : update_out) !== 1'b1 && n < lim) begin
         @(posedge clk);
         n++;
      end
      if (must && n >= lim) begin
         fail("pulse timeout");
         summarize();
      end
   endtask

   task automatic period(input logic [10:0] c, input bit s, input int e);
      int n;
      set_cfg(c);
      repeat (2) begin
         wait_pulse(s, 300, 1'b1, n);
         @(posedge clk);
      end
      wait_pulse(s, 300, 1'b1, n);
      check_num(n + 1, e);
   endtask

   task automatic shared(input logic [10:0] c, input logic [1:0] p, input int e);
      int n;
      set_cfg(c);
      repeat (3) @(posedge clk);
      {shared_manual_in, shared_second_in} <= p;
      @(posedge clk);
      {shared_manual_in, shared_second_in} <= 2'h0;
      wait_pulse(1'b0, 6, 1'b0, n);
      check_num(n < 6, e);
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial begin
      logic [31:0] d;
      logic [1:0] r;
      {sys_rst, ce, s_axi_bready, s_axi_rready} = 4'hf;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, sym_valid} = 4'h0;
      {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = 22'h0;
      {s_axi_wdata, s_axi_wstrb, sym_code, ev, lvl} = 50'h0;
      s_axi_wstrb = 4'hf;
      {shared_second_in, shared_manual_in} = 2'h0;
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      for (int a = 0; a < 40; a += 4) begin
         rd(a[7:0], d, r);
         check32(d, 32'h0);
      end
      wr(8'h28, 32'h1, r);
      check_resp(r, `RESP_SLVERR);
      rd(8'h28, d, r);
      check_resp(r, `RESP_SLVERR);
      check32(d, 32'h0);
      wr(`OFS_COUNTER_CONFIG, 32'h514, r);
      check_resp(r, `RESP_OKAY);
      rd(`OFS_COUNTER_CONFIG, d, r);
      check32(d, 32'h114);
      lvl <= 3'h1;
      rd(`OFS_STATUS, d, r);
      check32(d, 32'h1);
      lvl <= 3'h0;
      rd(`OFS_STATUS, d, r);
      check32(d, 32'h0);
      foreach (rows[i]) run_row(rows[i]);
      lvl <= 3'h1;
      line_case(11'h010, "+", "-++--+", 16'h2);
      line_case(11'h010, "+", "000+-0-+", 16'h2);
      line_case(11'h110, "+", "000+-0-+", 16'h0);
      line_case(11'h150, "+", "000+-00-", 16'h0);
      line_case(11'h011, "+", "0000000000000000-", 16'h1);
      line_case(11'h011, "+", "000000000000000-", 16'h0);
      line_case(11'h111, "+", "00000000-", 16'h1);
      line_case(11'h050, "++", "--++-++", 16'h3);
      line_case(11'h051, "++", "--++-++", 16'h1);
      period(11'h000, 1'b0, 100);
      period(11'h008, 1'b0, 20);
      period(11'h048, 1'b0, 30);
      period(11'h010, 1'b1, 100);
      shared(11'h018, 2'h2, 0);
      shared(11'h018, 2'h1, 1);
      shared(11'h020, 2'h1, 0);
      shared(11'h020, 2'h2, 1);
      lvl <= 3'h0;
      set_cfg(11'h410);
      ev <= 9'h002;
      sym_valid <= 1'b1;
      sym_code <= 2'h1;
      repeat (65540) @(posedge clk);
      ev <= 9'h0;
      sym_valid <= 1'b0;
      repeat (3) @(posedge clk);
      set_cfg(11'h410);
      rd_count(`OFS_PATH_LOW, 16'hffff);
      rd_count(`OFS_LCV_LOW, 16'hffff);
      summarize();
   end
endmodule // tb_line_path_error_counters
